// [src/pdc_pll_ctrl.sv]
/*
 * reset and vco calibration sequencer, counter dividers, prescalers and
 * phase detector of the pll, with a plain register port.
 * assumes pins are synchronous levels and clock ticks are synchronous one-cycle pulses on core_clk.
 */
`timescale 1ns/10ps
`include "pdc_map.svh"

module pdc_pll_ctrl (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// control pins
	input  wire logic        powerDownN,
	input  wire logic        resetPinLow,
	input  wire logic        supplyOk,
	// clock ticks, one per input period
	input  wire logic        primaryRefTick,
	input  wire logic        secondaryRefTick,
	input  wire logic        vcoTick,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic      [31:0] regRdData,
	// divider and phase detector
	output logic             prescalerAOut,
	output logic             prescalerBOut,
	output logic             phaseDetRef,
	output logic             phaseDetFb,
	output logic             chargePumpUp,
	output logic             chargePumpDown,
	// sequencer and filter
	output logic             outputsHeld,
	output logic             calActive,
	output logic      [2:0]  internalFilterResistor,
	output logic      [2:0]  internalFilterCapacitor
);
	localparam int SETTLE_CYC = (`PDC_SETTLE_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS;
	localparam int CAL_CYC    = (`PDC_CAL_NS + `PDC_CLK_PERIOD_NS - 1) / `PDC_CLK_PERIOD_NS;
	localparam logic [11:0] SETTLE_END = 12'(SETTLE_CYC - 1);
	localparam logic [11:0] CAL_END    = 12'(CAL_CYC - 1);

	pdc_pkg::pdc_state_e state_q;
	logic [10:0] ctrl_q;
	logic [3:0]  refDiv_q;
	logic [13:0] inDiv_q;
	logic [7:0]  fbDiv1_q;
	logic [9:0]  fbDiv2_q;
	logic [7:0]  psA_q;
	logic [7:0]  psB_q;
	logic [11:0] timer_q;
	logic        softPrev_q;
	logic        pumpUp_q;
	logic        pumpDn_q;
	logic        held_q;
	logic        calAct_q;
	logic [31:0] rdData_q;
	logic [2:0]  filterRes_q;
	logic [2:0]  filterCap_q;
	logic        pinsHigh;
	logic        softStart;
	logic        running;
	logic        wrOk;
	logic [5:0]  divIn;
	logic [5:0]  divOut;
	pdc_pkg::pdc_ratio_t divRatio [6];

	assign pinsHigh  = powerDownN && resetPinLow;
	assign softStart = softPrev_q && !ctrl_q[`PDC_CTRL_SOFT];
	assign running   = state_q == pdc_pkg::ST_RUN;
	assign wrOk      = regWrEn && pinsHigh;

	// ----------------------------------------
	// reset and calibration sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn || !pinsHigh) begin
			state_q <= pdc_pkg::ST_HOLD;
			timer_q <= 12'h000;
		end else begin
			timer_q <= timer_q + 12'h001;
			case (state_q)
				pdc_pkg::ST_HOLD: begin
					state_q <= pdc_pkg::ST_SETTLE;
					timer_q <= 12'h000;
				end
				pdc_pkg::ST_SETTLE: begin
					if (softStart) begin
						timer_q <= 12'h000;
					end else if (timer_q >= SETTLE_END) begin
						timer_q <= SETTLE_END;
						if (supplyOk) begin
							state_q <= pdc_pkg::ST_CAL;
							timer_q <= 12'h000;
						end
					end
				end
				pdc_pkg::ST_CAL: begin
					if (softStart) begin
						state_q <= pdc_pkg::ST_SETTLE;
						timer_q <= 12'h000;
					end else if (timer_q == CAL_END) begin
						state_q <= pdc_pkg::ST_RUN;
					end
				end
				pdc_pkg::ST_RUN: begin
					if (softStart) begin
						state_q <= pdc_pkg::ST_SETTLE;
						timer_q <= 12'h000;
					end
				end
				default: begin
					state_q <= pdc_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// outputs stay quiet until calibration has finished
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			held_q <= 1'b1;
			calAct_q <= 1'b0;
		end else begin
			held_q <= !running || softStart || !pinsHigh;
			calAct_q <= pinsHigh && state_q == pdc_pkg::ST_CAL;
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// pins low force defaults, so a pin release always starts from them
	always_ff @(posedge core_clk) begin
		if (!rstn || !pinsHigh) begin
			ctrl_q   <= `PDC_RST_CTRL;
			refDiv_q <= `PDC_RST_REFDIV;
			inDiv_q  <= `PDC_RST_INDIV;
			fbDiv1_q <= `PDC_RST_FBDIV1;
			fbDiv2_q <= `PDC_RST_FBDIV2;
			psA_q    <= `PDC_RST_PSA;
			psB_q    <= `PDC_RST_PSB;
		end else if (wrOk) begin
			case (regAddr)
				`PDC_OFS_CTRL: begin
					ctrl_q <= regWrData[10:0];
				end
				`PDC_OFS_REFDIV: begin
					refDiv_q <= regWrData[3:0];
				end
				`PDC_OFS_INDIV: begin
					inDiv_q <= regWrData[13:0];
				end
				`PDC_OFS_FBDIV1: begin
					fbDiv1_q <= regWrData[7:0];
				end
				`PDC_OFS_FBDIV2: begin
					fbDiv2_q <= regWrData[9:0];
				end
				`PDC_OFS_PSDIV: begin
					psA_q <= regWrData[7:0];
					psB_q <= regWrData[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn || !pinsHigh) begin
			softPrev_q <= 1'b0;
		end else begin
			softPrev_q <= ctrl_q[`PDC_CTRL_SOFT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rdData_q <= 32'h00000000;
		end else if (regRdEn) begin
			case (regAddr)
				`PDC_OFS_CTRL:   rdData_q <= {21'h000000, ctrl_q};
				`PDC_OFS_REFDIV: rdData_q <= {28'h0000000, refDiv_q};
				`PDC_OFS_INDIV:  rdData_q <= {18'h00000, inDiv_q};
				`PDC_OFS_FBDIV1: rdData_q <= {24'h000000, fbDiv1_q};
				`PDC_OFS_FBDIV2: rdData_q <= {22'h000000, fbDiv2_q};
				`PDC_OFS_PSDIV:  rdData_q <= {16'h0000, psB_q, psA_q};
				`PDC_OFS_STATUS: rdData_q <= {28'h0000000, held_q, supplyOk, state_q};
				default:         rdData_q <= 32'h00000000;
			endcase
		end else begin
			rdData_q <= 32'h00000000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			filterRes_q <= 3'h0;
			filterCap_q <= 3'h0;
		end else begin
			filterRes_q <= ctrl_q[`PDC_CTRL_RES_HI:`PDC_CTRL_RES_LO];
			filterCap_q <= ctrl_q[`PDC_CTRL_CAP_HI:`PDC_CTRL_CAP_LO];
		end
	end

	// ----------------------------------------
	// divider chain
	// ----------------------------------------
	// 0 ref, 1 input, 2 fb stage 1, 3 fb stage 2, 4 prescaler a, 5 prescaler b
	always_comb begin
		divIn[0]    = primaryRefTick;
		divIn[1]    = ctrl_q[`PDC_CTRL_REFSEL] ? secondaryRefTick : divOut[0];
		divIn[2]    = divOut[4];
		divIn[3]    = divOut[2];
		divIn[4]    = vcoTick;
		divIn[5]    = vcoTick;
		divRatio[0] = {10'h000, refDiv_q};
		divRatio[1] = inDiv_q;
		divRatio[2] = {6'h00, fbDiv1_q};
		divRatio[3] = {4'h0, fbDiv2_q};
		divRatio[4] = {6'h00, psA_q};
		divRatio[5] = {6'h00, psB_q};
	end

	for (genvar i = 0; i < 6; i++) begin : g_div
		logic [13:0] cnt_q;
		logic        out_q;
		always_ff @(posedge core_clk) begin
			if (!rstn || !running) begin
				cnt_q <= 14'h0000;
				out_q <= 1'b0;
			end else begin
				out_q <= divIn[i] && (cnt_q >= divRatio[i]);
				if (divIn[i]) begin
					cnt_q <= (cnt_q >= divRatio[i]) ? 14'h0000 : cnt_q + 14'h0001;
				end
			end
		end
		assign divOut[i] = out_q;

		a_div_period: assert property (@(posedge core_clk) disable iff (!rstn)
			running && $past(running) && divIn[i] && cnt_q >= divRatio[i] |=> divOut[i] || !running)
			else $error("divider missed its terminal count");
	end

	// ----------------------------------------
	// phase detector
	// ----------------------------------------
	// both pulses at once cancel, as a reset race would in a real detector
	always_ff @(posedge core_clk) begin
		if (!rstn || !running) begin
			pumpUp_q <= 1'b0;
			pumpDn_q <= 1'b0;
		end else begin
			pumpUp_q <= (pumpUp_q || divOut[1]) && !(pumpDn_q || divOut[3]);
			pumpDn_q <= (pumpDn_q || divOut[3]) && !(pumpUp_q || divOut[1]);
		end
	end

	assign regRdData               = rdData_q;
	assign prescalerAOut           = divOut[4];
	assign prescalerBOut           = divOut[5];
	assign phaseDetRef             = divOut[1];
	assign phaseDetFb              = divOut[3];
	assign chargePumpUp            = pumpUp_q;
	assign chargePumpDown          = pumpDn_q;
	assign outputsHeld             = held_q;
	assign calActive               = calAct_q;
	assign internalFilterResistor  = filterRes_q;
	assign internalFilterCapacitor = filterCap_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_pin_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		!pinsHigh |=> state_q == pdc_pkg::ST_HOLD && outputsHeld)
		else $error("pin low did not hold reset");
	a_pin_defaults: assert property (@(posedge core_clk) disable iff (!rstn)
		!pinsHigh |=> refDiv_q == `PDC_RST_REFDIV && fbDiv1_q == `PDC_RST_FBDIV1)
		else $error("defaults not reloaded");
	a_release_settle: assert property (@(posedge core_clk) disable iff (!rstn)
		state_q == pdc_pkg::ST_HOLD && pinsHigh && rstn |=> state_q == pdc_pkg::ST_SETTLE)
		else $error("release did not start sequence");
	a_soft_keep: assert property (@(posedge core_clk) disable iff (!rstn)
		softStart && pinsHigh && !wrOk |=> $stable(inDiv_q) && state_q == pdc_pkg::ST_SETTLE)
		else $error("soft reset lost settings");
	a_cal_gate: assert property (@(posedge core_clk) disable iff (!rstn)
		state_q == pdc_pkg::ST_SETTLE && (!supplyOk || timer_q < SETTLE_END)
		|=> state_q != pdc_pkg::ST_CAL)
		else $error("calibration started early");
	a_cal_held: assert property (@(posedge core_clk) disable iff (!rstn)
		calActive |-> outputsHeld && !prescalerAOut && !prescalerBOut)
		else $error("clock active during calibration");
	a_run_normal: assert property (@(posedge core_clk) disable iff (!rstn)
		running |-> $past(pinsHigh) && $past(state_q) != pdc_pkg::ST_HOLD)
		else $error("running without pins high");
	a_pump_up: assert property (@(posedge core_clk) disable iff (!rstn)
		running && divOut[1] && !divOut[3] && !pumpDn_q |=> chargePumpUp || !running)
		else $error("pump up missing");
	a_filter_sel: assert property (@(posedge core_clk) disable iff (!rstn)
		##1 internalFilterResistor == $past(ctrl_q[`PDC_CTRL_RES_HI:`PDC_CTRL_RES_LO]))
		else $error("filter select not applied");

	c_calibrated: cover property (@(posedge core_clk) disable iff (!rstn)
		state_q == pdc_pkg::ST_CAL ##1 running);
	c_soft_recal: cover property (@(posedge core_clk) disable iff (!rstn)
		running && softStart);
	c_pump_down: cover property (@(posedge core_clk) disable iff (!rstn) chargePumpDown);
	c_secondary: cover property (@(posedge core_clk) disable iff (!rstn)
		ctrl_q[`PDC_CTRL_REFSEL] && phaseDetRef);
endmodule

// [src/pdc_map.svh]
/*
 * offsets, field positions, reset values and timing in nanoseconds of the pll control block.
 * assumes one 40 MHz core clock; ratio fields hold ratio minus one.
 */
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDC_OFS_CTRL     8'h00
`define PDC_OFS_REFDIV   8'h04
`define PDC_OFS_INDIV    8'h08
`define PDC_OFS_FBDIV1   8'h0C
`define PDC_OFS_FBDIV2   8'h10
`define PDC_OFS_PSDIV    8'h14
`define PDC_OFS_STATUS   8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define PDC_CTRL_SOFT    0
`define PDC_CTRL_REFSEL  1
`define PDC_CTRL_RES_LO  4
`define PDC_CTRL_RES_HI  6
`define PDC_CTRL_CAP_LO  8
`define PDC_CTRL_CAP_HI  10

// ----------------------------------------
// reset values
// ----------------------------------------
`define PDC_RST_CTRL     11'h000
`define PDC_RST_REFDIV   4'h0
`define PDC_RST_INDIV    14'h0000
`define PDC_RST_FBDIV1   8'h03
`define PDC_RST_FBDIV2   10'h009
`define PDC_RST_PSA      8'h03
`define PDC_RST_PSB      8'h03

// ----------------------------------------
// timing
// ----------------------------------------
`define PDC_CLK_PERIOD_NS 25
`define PDC_SETTLE_NS     100000
`define PDC_CAL_NS        1600

`endif

// [src/pdc_pkg.sv]
/*
 * types of the pll control block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pdc_pkg;
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_SETTLE,
		ST_CAL,
		ST_RUN
	} pdc_state_e;

	typedef logic [13:0] pdc_ratio_t;
endpackage

// [bench/pdc_tick_src.sv]
/*
 * tick source standing in for the reference inputs and the vco.
 * assumes ticks are sampled on core_clk and one pulse means one period.
 */
`timescale 1ns/10ps

module pdc_tick_src (
	// clock
	input  wire logic core_clk,
	// enables
	input  wire logic refEn,
	input  wire logic vcoEn,
	// ticks
	output logic      primaryRefTick,
	output logic      secondaryRefTick,
	output logic      vcoTick
);
	// ----------------------------------------
	// tick generation
	// ----------------------------------------
	// secondary runs at the primary rate, well inside the switching band
	// one tick every other cycle keeps every stage within its rate limits
	initial begin
		primaryRefTick = 1'b0;
		secondaryRefTick = 1'b0;
		vcoTick = 1'b0;
		forever begin
			@(posedge core_clk);
			primaryRefTick <= refEn & ~primaryRefTick;
			secondaryRefTick <= refEn & ~secondaryRefTick;
			vcoTick <= vcoEn & ~vcoTick;
		end
	end
endmodule

// [bench/pdc_pll_ctrl_tb_top.sv]
/*
 * self-checking bench of the pll control block.
 * assumes the register map header and the tick source model.
 */
`timescale 1ns/10ps
`include "pdc_map.svh"

module pdc_pll_ctrl_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        core_clk = 1'b0;
	logic        rstn, powerDownN, resetPinLow, supplyOk, refEn, vcoEn;
	logic        primaryRefTick, secondaryRefTick, vcoTick;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData;
	logic        regWrEn, regRdEn;
	logic        prescalerAOut, prescalerBOut, phaseDetRef, phaseDetFb;
	logic        chargePumpUp, chargePumpDown, outputsHeld, calActive;
	logic [2:0]  internalFilterResistor, internalFilterCapacitor;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          seed = 32'h80DA;
	int          calCycles, gap, ctrl;
	int          cfg[6];
	logic [7:0]  ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
	logic [31:0] dflt[7] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h9, 32'h303, 32'h0};

	pdc_pll_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .powerDownN(powerDownN),
		.resetPinLow(resetPinLow), .supplyOk(supplyOk), .primaryRefTick(primaryRefTick),
		.secondaryRefTick(secondaryRefTick), .vcoTick(vcoTick), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.prescalerAOut(prescalerAOut), .prescalerBOut(prescalerBOut),
		.phaseDetRef(phaseDetRef), .phaseDetFb(phaseDetFb), .chargePumpUp(chargePumpUp),
		.chargePumpDown(chargePumpDown), .outputsHeld(outputsHeld), .calActive(calActive),
		.internalFilterResistor(internalFilterResistor),
		.internalFilterCapacitor(internalFilterCapacitor));

	pdc_tick_src u_src (.core_clk(core_clk), .refEn(refEn), .vcoEn(vcoEn),
		.primaryRefTick(primaryRefTick), .secondaryRefTick(secondaryRefTick),
		.vcoTick(vcoTick));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1 check(name, exp, regRdData);
	endtask

	// counts calibration cycles until the outputs come free
	task automatic wait_run();
		int k;
		calCycles = 0;
		// the first cycles are counted too: calibration may start at once
		for (k = 0; k < 6000 && (k < 4 || outputsHeld !== 1'b0); k++) begin
			@(posedge core_clk);
			#1;
			if (calActive === 1'b1) calCycles++;
		end
		check("calibration cycles", `PDC_CAL_NS / `PDC_CLK_PERIOD_NS, calCycles);
		check("outputs released", 0, outputsHeld);
	endtask

	// input ticks between the 2nd and 3rd output pulse, past any restart
	task automatic measure(input int sel, output int g);
		int c, n, k;
		logic t, o;
		c = 0;
		n = 0;
		g = -1;
		for (k = 0; k < 3000 && n < 3; k++) begin
			@(posedge core_clk);
			#1;
			t = (sel == 0) ? primaryRefTick : vcoTick;
			o = (sel == 0) ? phaseDetRef : (sel == 1) ? prescalerAOut :
				(sel == 2) ? prescalerBOut : phaseDetFb;
			if (o === 1'b1) begin
				n++;
				if (n == 3) g = c;
				c = 0;
			end
			if (t === 1'b1) c++;
		end
	endtask

	function automatic int exp_gap(input int sel);
		case (sel)
			0: exp_gap = (ctrl[`PDC_CTRL_REFSEL] ? 1 : cfg[0] + 1) * (cfg[1] + 1);
			1: exp_gap = cfg[2] + 1;
			2: exp_gap = cfg[3] + 1;
			default: exp_gap = (cfg[2] + 1) * (cfg[4] + 1) * (cfg[5] + 1);
		endcase
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(negedge core_clk) begin
		if (calActive === 1'b1 && (outputsHeld !== 1'b1 || prescalerAOut !== 1'b0)) begin
			n_mismatch++;
			$display("mismatch outputs during calibration expected 1 seen 0");
		end
	end

	initial begin
		repeat (80000) @(posedge core_clk);
		n_mismatch++;
		tally_and_finish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{regAddr, regWrData, regWrEn, regRdEn, rstn, supplyOk} = '0;
		{powerDownN, resetPinLow, refEn, vcoEn} = 4'hF;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		calCycles = 0;
		repeat (4200) begin
			@(posedge core_clk);
			#1;
			if (calActive === 1'b1) calCycles++;
		end
		check("calibration before supply good", 0, calCycles);
		rdchk("status settling", `PDC_OFS_STATUS, 32'h9);
		supplyOk <= 1'b1;
		wait_run();
		rdchk("status running", `PDC_OFS_STATUS, 32'h7);
		for (int j = 0; j < 7; j++) rdchk("default", ofs[j], dflt[j]);
		for (int it = 0; it < 3; it++) begin
			foreach (cfg[j]) cfg[j] = (it == 0) ? 0 : $random(seed) & 3;
			if (it == 1) cfg[0] = 15;
			wr(`PDC_OFS_REFDIV, cfg[0]);
			wr(`PDC_OFS_INDIV, cfg[1]);
			wr(`PDC_OFS_PSDIV, (cfg[3] << 8) | cfg[2]);
			wr(`PDC_OFS_FBDIV1, cfg[4]);
			wr(`PDC_OFS_FBDIV2, cfg[5]);
			// last pass feeds the input divider from the secondary reference
			ctrl = ($random(seed) & 32'h770) | ((it == 2) ? 32'h2 : 32'h0);
			wr(`PDC_OFS_CTRL, ctrl | 1);
			wr(`PDC_OFS_CTRL, ctrl);
			wait_run();
			rdchk("fb stage one kept", `PDC_OFS_FBDIV1, cfg[4]);
			check("filter resistor", (ctrl >> 4) & 7, internalFilterResistor);
			check("filter capacitor", (ctrl >> 8) & 7, internalFilterCapacitor);
			for (int s = 0; s < 4; s++) begin
				measure(s, gap);
				check("divider gap", exp_gap(s), gap);
			end
		end
		vcoEn <= 1'b0;
		repeat (300) @(posedge core_clk);
		#1 check("pump up", 1, chargePumpUp);
		check("pump down", 0, chargePumpDown);
		// feedback alone: first pulse cancels up, the next raises down
		refEn <= 1'b0;
		vcoEn <= 1'b1;
		repeat (400) @(posedge core_clk);
		#1 check("pump down alone", 1, chargePumpDown);
		check("pump up cleared", 0, chargePumpUp);
		refEn <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			if (p == 0) powerDownN <= 1'b0;
			else resetPinLow <= 1'b0;
			repeat (4) @(posedge core_clk);
			#1 check("held in reset", 1, outputsHeld);
			wr(`PDC_OFS_FBDIV1, 32'h55);
			powerDownN <= 1'b1;
			resetPinLow <= 1'b1;
			wait_run();
			rdchk("fb stage one reloaded", `PDC_OFS_FBDIV1, 32'h3);
			rdchk("prescaler reloaded", `PDC_OFS_PSDIV, 32'h303);
		end
		tally_and_finish();
	end
endmodule
